//--- qca_pkg.sv
package qca_pkg;

    // register byte offsets
    localparam logic [11:0] OFS_DATA0 = 12'h804;
    localparam logic [11:0] OFS_DATA7 = 12'h820;
    localparam logic [11:0] OFS_MASK0 = 12'h824;
    localparam logic [11:0] OFS_MASK7 = 12'h840;
    localparam logic [11:0] OFS_CMD   = 12'h844;
    localparam logic [11:0] OFS_ERR   = 12'h848;
    localparam int          NUM_WORDS = 8;
    localparam int          CTX_W     = 256;

    // command register fields
    localparam int CMD_BUSY   = 0;
    localparam int CMD_SEL_LO = 1;
    localparam int SEL_W      = 4;
    localparam int CMD_OP_LO  = 5;
    localparam int OP_W       = 2;
    localparam int CMD_IDX_LO = 7;
    localparam int IDX_W      = 13;
    localparam int QID_W      = 11;

    // command opcodes
    localparam logic [1:0] OP_CLEAR = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [1:0] OP_INV   = 2'h3;

    // context selects
    localparam logic [3:0] SEL_SW_DESC      = 4'h0;
    localparam logic [3:0] SEL_TIMER        = 4'h5;
    localparam logic [3:0] SEL_CMPT         = 4'h6;
    localparam logic [3:0] SEL_HOST_PROFILE = 4'ha;
    localparam logic [3:0] SEL_FUNCTION_MAP_SELECT         = 4'hc;

    // context field positions
    localparam int FUNCTION_MAP_SELECT_BASE_LO = 0;
    localparam int FUNCTION_MAP_SELECT_BASE_W  = 11;
    localparam int FUNCTION_MAP_SELECT_QMAX_LO = 32;
    localparam int FUNCTION_MAP_SELECT_QMAX_W  = 12;
    localparam int QEN_BIT      = 32;
    localparam int CREDIT_LO    = 48;
    localparam int CREDIT_W     = 16;

    // error status bits
    localparam int ERR_RANGE_BIT = 0;

    // values after reset
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } qca_state_t;

endpackage

//--- qca_function_map_select_regs.sv
`timescale 1ns/1ps

module qca_function_map_select_regs #(
    parameter int NUM_QUEUES = 16,
    parameter int NUM_FUNCS  = 16
) (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [11:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_we,
    input  wire logic        reg_re,
    input  wire logic        reg_from_pf,
    output logic      [31:0] reg_rdata,
    input  wire logic        qwin_valid,
    input  wire logic [12:0] qwin_func,
    input  wire logic [10:0] qwin_lqid,
    output logic             qwin_phys_valid,
    output logic      [10:0] qwin_phys_qid,
    output logic             qwin_error,
    input  wire logic        cmpt_cidx_upd,
    input  wire logic [10:0] cmpt_cidx_qid,
    output logic [NUM_QUEUES-1:0] cmpt_armed,
    output logic             dsc_sts_valid,
    output logic      [10:0] dsc_sts_qid,
    output logic             dsc_sts_qinv,
    output logic      [15:0] dsc_sts_credits
);

    localparam int QW = $clog2(NUM_QUEUES);
    localparam int FW = $clog2(NUM_FUNCS);

    // refuse sizes the indexing cannot serve
    if (NUM_QUEUES < 2 || NUM_QUEUES > 2048 || (1 << QW) != NUM_QUEUES) begin : g_chk_q
        $error("NUM_QUEUES must be a power of two from 2 to 2048");
    end
    if (NUM_FUNCS < 2 || NUM_FUNCS > 8192 || (1 << FW) != NUM_FUNCS) begin : g_chk_f
        $error("NUM_FUNCS must be a power of two from 2 to 8192");
    end

    // register state
    qca_pkg::qca_state_t state;
    qca_pkg::qca_state_t next_state;
    logic [31:0] data_word [qca_pkg::NUM_WORDS];
    logic [31:0] next_data_word [qca_pkg::NUM_WORDS];
    logic [31:0] mask_word [qca_pkg::NUM_WORDS];
    logic [31:0] next_mask_word [qca_pkg::NUM_WORDS];
    logic        cmd_busy;
    logic        next_cmd_busy;
    logic [3:0]  cmd_sel;
    logic [3:0]  next_cmd_sel;
    logic [1:0]  cmd_op;
    logic [1:0]  next_cmd_op;
    logic [12:0] cmd_idx;
    logic [12:0] next_cmd_idx;
    logic [31:0] err_sts;
    logic [31:0] next_err_sts;
    logic [31:0] next_reg_rdata;

    // context storage; left unreset, software clears before use; the function map tables are reset
    logic [qca_pkg::CTX_W-1:0] ctx_mem [16*NUM_QUEUES];
    logic [10:0] function_map_select_base [NUM_FUNCS];
    logic [11:0] function_map_select_qmax [NUM_FUNCS];

    // decode
    logic        data_hit;
    logic        mask_hit;
    logic [2:0]  data_sel;
    logic [2:0]  mask_sel;
    logic [11:0] data_off;
    logic [11:0] mask_off;
    logic        cmd_go;
    logic        cfg_wr_ok;

    assign data_off = reg_addr - qca_pkg::OFS_DATA0;
    assign mask_off = reg_addr - qca_pkg::OFS_MASK0;
    assign data_sel = data_off[4:2];
    assign mask_sel = mask_off[4:2];
    assign data_hit = (reg_addr >= qca_pkg::OFS_DATA0) && (reg_addr <= qca_pkg::OFS_DATA7)
                      && (reg_addr[1:0] == 2'h0);
    assign mask_hit = (reg_addr >= qca_pkg::OFS_MASK0) && (reg_addr <= qca_pkg::OFS_MASK7)
                      && (reg_addr[1:0] == 2'h0);
    // writes from a virtual function never reach the indirect set
    assign cfg_wr_ok = reg_we && reg_from_pf && (state == qca_pkg::ST_IDLE);
    // a command arriving with bit 0 set, or while busy, launches nothing
    assign cmd_go = cfg_wr_ok && (reg_addr == qca_pkg::OFS_CMD)
                    && !reg_wdata[qca_pkg::CMD_BUSY];

    // execution operands
    logic [qca_pkg::CTX_W-1:0] data_vec;
    logic [qca_pkg::CTX_W-1:0] mask_vec;
    logic [qca_pkg::CTX_W-1:0] old_ctx;
    logic [qca_pkg::CTX_W-1:0] new_ctx;
    logic [QW+3:0]             mem_idx;
    logic                      is_function_map_select;
    logic                      qid_ok;
    logic                      func_ok;
    logic                      ctx_we;
    logic                      function_map_select_we;
    logic                      rd_load;
    logic                      sts_fire;
    logic [10:0]               cmd_qid;

    assign cmd_qid = cmd_idx[10:0];
    assign is_function_map_select = (cmd_sel == qca_pkg::SEL_FUNCTION_MAP_SELECT);
    assign qid_ok  = (cmd_idx < 13'(NUM_QUEUES));
    assign func_ok = (cmd_idx < 13'(NUM_FUNCS));
    assign mem_idx = {cmd_sel, cmd_qid[QW-1:0]};

    // gather words into context vectors and fetch the old context
    always_comb begin
        data_vec = '0;
        mask_vec = '0;
        old_ctx  = '0;
        for (int i = 0; i < qca_pkg::NUM_WORDS; i++) begin
            data_vec[i*32 +: 32] = data_word[i];
            mask_vec[i*32 +: 32] = mask_word[i];
        end
        if (is_function_map_select) begin
            if (func_ok) begin
                old_ctx[qca_pkg::FUNCTION_MAP_SELECT_BASE_LO +: qca_pkg::FUNCTION_MAP_SELECT_BASE_W] =
                    function_map_select_base[cmd_idx[FW-1:0]];
                old_ctx[qca_pkg::FUNCTION_MAP_SELECT_QMAX_LO +: qca_pkg::FUNCTION_MAP_SELECT_QMAX_W] =
                    function_map_select_qmax[cmd_idx[FW-1:0]];
            end
        end else if (qid_ok) begin
            old_ctx = ctx_mem[mem_idx];
        end
    end

    // opcode decode for the execute cycle
    always_comb begin
        new_ctx  = old_ctx;
        ctx_we   = 1'b0;
        function_map_select_we  = 1'b0;
        rd_load  = 1'b0;
        sts_fire = 1'b0;
        if (state == qca_pkg::ST_EXEC) begin
            case (cmd_op)
                qca_pkg::OP_CLEAR: begin
                    // timer context has no clear; the request is dropped
                    if (cmd_sel != qca_pkg::SEL_TIMER) begin
                        new_ctx  = '0;
                        ctx_we   = 1'b1;
                        sts_fire = !is_function_map_select;
                    end
                end
                qca_pkg::OP_WRITE: begin
                    new_ctx = (old_ctx & ~mask_vec) | (data_vec & mask_vec);
                    ctx_we  = 1'b1;
                end
                qca_pkg::OP_READ: begin
                    rd_load = 1'b1;
                end
                qca_pkg::OP_INV: begin
                    new_ctx[qca_pkg::QEN_BIT] = 1'b0;
                    ctx_we   = 1'b1;
                    sts_fire = !is_function_map_select;
                end
                default: begin
                    ctx_we = 1'b0;
                end
            endcase
            function_map_select_we = ctx_we && is_function_map_select && func_ok;
            ctx_we  = ctx_we && !is_function_map_select && qid_ok;
        end
    end

    // context and table storage
    always_ff @(posedge clock) begin
        if (ctx_we) begin
            ctx_mem[mem_idx] <= new_ctx;
        end
    end

    // table entries are control state, so they come up at zero queues
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int f = 0; f < NUM_FUNCS; f++) begin
                function_map_select_base[f] <= '0;
                function_map_select_qmax[f] <= '0;
            end
        end else if (function_map_select_we) begin
            function_map_select_base[cmd_idx[FW-1:0]] <=
                new_ctx[qca_pkg::FUNCTION_MAP_SELECT_BASE_LO +: qca_pkg::FUNCTION_MAP_SELECT_BASE_W];
            function_map_select_qmax[cmd_idx[FW-1:0]] <=
                new_ctx[qca_pkg::FUNCTION_MAP_SELECT_QMAX_LO +: qca_pkg::FUNCTION_MAP_SELECT_QMAX_W];
        end
    end

    // logical queue window translation
    logic [10:0] win_base;
    logic [11:0] win_qmax;
    logic        win_in_range;
    logic        next_phys_valid;
    logic [10:0] next_phys_qid;
    logic        next_qwin_error;

    always_comb begin
        win_base = '0;
        win_qmax = '0;
        if (qwin_func < 13'(NUM_FUNCS)) begin
            win_base = function_map_select_base[qwin_func[FW-1:0]];
            win_qmax = function_map_select_qmax[qwin_func[FW-1:0]];
        end
        win_in_range    = ({1'b0, qwin_lqid} < win_qmax);
        next_phys_valid = qwin_valid && win_in_range;
        next_phys_qid   = 11'(win_base + qwin_lqid);
        next_qwin_error = qwin_valid && !win_in_range;
    end

    // bus, command and status next values
    logic [NUM_QUEUES-1:0] next_cmpt_armed;
    logic                  next_sts_valid;
    logic [10:0]           next_sts_qid;
    logic                  next_sts_qinv;
    logic [15:0]           next_sts_credits;

    always_comb begin
        next_state    = state;
        next_cmd_busy = cmd_busy;
        next_cmd_sel  = cmd_sel;
        next_cmd_op   = cmd_op;
        next_cmd_idx  = cmd_idx;
        next_err_sts  = err_sts;
        for (int i = 0; i < qca_pkg::NUM_WORDS; i++) begin
            next_data_word[i] = data_word[i];
            next_mask_word[i] = mask_word[i];
        end
        if (cfg_wr_ok && data_hit) begin
            next_data_word[data_sel] = reg_wdata;
        end
        if (cfg_wr_ok && mask_hit) begin
            next_mask_word[mask_sel] = reg_wdata;
        end
        if (cmd_go) begin
            next_cmd_sel  = reg_wdata[qca_pkg::CMD_SEL_LO +: qca_pkg::SEL_W];
            next_cmd_op   = reg_wdata[qca_pkg::CMD_OP_LO +: qca_pkg::OP_W];
            next_cmd_idx  = reg_wdata[qca_pkg::CMD_IDX_LO +: qca_pkg::IDX_W];
            next_cmd_busy = 1'b1;
            next_state    = qca_pkg::ST_EXEC;
        end
        if (state == qca_pkg::ST_EXEC) begin
            next_cmd_busy = 1'b0;
            next_state    = qca_pkg::ST_IDLE;
            if (rd_load) begin
                for (int i = 0; i < qca_pkg::NUM_WORDS; i++) begin
                    next_data_word[i] = old_ctx[i*32 +: 32];
                end
            end
        end
        // write-one-to-clear, but a fresh error in the same cycle survives
        if (reg_we && reg_from_pf && reg_addr == qca_pkg::OFS_ERR) begin
            next_err_sts = err_sts & ~reg_wdata;
        end
        if (next_qwin_error) begin
            next_err_sts[qca_pkg::ERR_RANGE_BIT] = 1'b1;
        end
        // read mux; unmapped offsets read zero
        next_reg_rdata = qca_pkg::RST_WORD;
        if (reg_re) begin
            if (data_hit) begin
                next_reg_rdata = data_word[data_sel];
            end else if (mask_hit) begin
                next_reg_rdata = mask_word[mask_sel];
            end else if (reg_addr == qca_pkg::OFS_CMD) begin
                next_reg_rdata = {12'h000, cmd_idx, cmd_op, cmd_sel, cmd_busy};
            end else if (reg_addr == qca_pkg::OFS_ERR) begin
                next_reg_rdata = err_sts;
            end
        end
        // completion arming: cleared by any clear, write or invalidate of the context, armed by first update
        next_cmpt_armed = cmpt_armed;
        if (ctx_we && cmd_sel == qca_pkg::SEL_CMPT) begin
            next_cmpt_armed[cmd_qid[QW-1:0]] = 1'b0;
        end
        if (cmpt_cidx_upd && cmpt_cidx_qid < 11'(NUM_QUEUES)) begin
            next_cmpt_armed[cmpt_cidx_qid[QW-1:0]] = 1'b1;
        end
        // queue-invalidated status with credits returned on invalidate
        next_sts_valid   = sts_fire;
        next_sts_qid     = sts_fire ? cmd_qid : dsc_sts_qid;
        next_sts_qinv    = sts_fire;
        next_sts_credits = (sts_fire && cmd_op == qca_pkg::OP_INV) ?
                           old_ctx[qca_pkg::CREDIT_LO +: qca_pkg::CREDIT_W] : 16'h0000;
    end

    // register everything but the context storage and the function map tables
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state           <= qca_pkg::ST_IDLE;
            cmd_busy        <= 1'b0;
            cmd_sel         <= '0;
            cmd_op          <= '0;
            cmd_idx         <= '0;
            err_sts         <= qca_pkg::RST_WORD;
            reg_rdata       <= qca_pkg::RST_WORD;
            qwin_phys_valid <= 1'b0;
            qwin_phys_qid   <= '0;
            qwin_error      <= 1'b0;
            cmpt_armed      <= '0;
            dsc_sts_valid   <= 1'b0;
            dsc_sts_qid     <= '0;
            dsc_sts_qinv    <= 1'b0;
            dsc_sts_credits <= '0;
            for (int i = 0; i < qca_pkg::NUM_WORDS; i++) begin
                data_word[i] <= qca_pkg::RST_WORD;
                mask_word[i] <= qca_pkg::RST_WORD;
            end
        end else begin
            state           <= next_state;
            cmd_busy        <= next_cmd_busy;
            cmd_sel         <= next_cmd_sel;
            cmd_op          <= next_cmd_op;
            cmd_idx         <= next_cmd_idx;
            err_sts         <= next_err_sts;
            reg_rdata       <= next_reg_rdata;
            qwin_phys_valid <= next_phys_valid;
            qwin_phys_qid   <= next_phys_qid;
            qwin_error      <= next_qwin_error;
            cmpt_armed      <= next_cmpt_armed;
            dsc_sts_valid   <= next_sts_valid;
            dsc_sts_qid     <= next_sts_qid;
            dsc_sts_qinv    <= next_sts_qinv;
            dsc_sts_credits <= next_sts_credits;
            for (int i = 0; i < qca_pkg::NUM_WORDS; i++) begin
                data_word[i] <= next_data_word[i];
                mask_word[i] <= next_mask_word[i];
            end
        end
    end

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_launch;
        cmd_go;
    endsequence

    sequence s_done;
        cmd_busy ##1 !cmd_busy;
    endsequence

    a_busy_one_cycle: assert property (s_launch |=> s_done)
        else $error("busy bit not held exactly one cycle");
    a_busy_refuse: assert property (cmd_busy |-> !cmd_go)
        else $error("command launched while busy");
    a_bit0_refuse: assert property (reg_we && reg_addr == qca_pkg::OFS_CMD
        && reg_wdata[0] && !cmd_busy |=> !cmd_busy)
        else $error("command with bit 0 set was launched");
    a_vf_refuse: assert property (reg_we && !reg_from_pf |-> !cmd_go)
        else $error("virtual function launched a command");
    a_clear_status: assert property (s_launch ##0 (reg_wdata[6:5] == qca_pkg::OP_CLEAR
        && reg_wdata[4:1] == qca_pkg::SEL_SW_DESC) |=> ##1 dsc_sts_valid && dsc_sts_qinv)
        else $error("clear gave no invalidated status");
    a_timer_no_clear: assert property (state == qca_pkg::ST_EXEC
        && cmd_sel == qca_pkg::SEL_TIMER && cmd_op == qca_pkg::OP_CLEAR |-> !ctx_we)
        else $error("timer context was cleared");
    a_inv_keeps: assert property (ctx_we && cmd_op == qca_pkg::OP_INV
        |-> !new_ctx[qca_pkg::QEN_BIT] && new_ctx[31:0] == old_ctx[31:0])
        else $error("invalidate changed more than queue enable");
    a_range_error: assert property (qwin_valid && !win_in_range
        |=> qwin_error && !qwin_phys_valid ##0 err_sts[0])
        else $error("out of range access not cancelled and logged");
    a_phys_qid: assert property (qwin_valid && win_in_range
        |=> qwin_phys_valid && qwin_phys_qid == $past(next_phys_qid))
        else $error("physical queue translation wrong");
    a_function_map_select_write: assert property (function_map_select_we |=> function_map_select_qmax[$past(cmd_idx[FW-1:0])]
        == $past(new_ctx[43:32]))
        else $error("function map entry not stored");
    a_cmpt_arm: assert property (cmpt_cidx_upd && cmpt_cidx_qid == 11'h000
        |=> cmpt_armed[0])
        else $error("consumer update did not arm completion");

endmodule

//--- test_queue_context_access_function_map_select.sv
`timescale 1ns/1ps

// one compare: counts it, reports a mismatch at once
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin err_total++; \
    $display("mismatch at %0t: %s", $time, m); end end

module test_queue_context_access_function_map_select;
    logic        clock;
    logic        sys_rst;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_we;
    logic        reg_re;
    logic        reg_from_pf;
    logic [31:0] reg_rdata;
    logic        qwin_valid;
    logic [12:0] qwin_func;
    logic [10:0] qwin_lqid;
    logic        qwin_phys_valid;
    logic [10:0] qwin_phys_qid;
    logic        qwin_error;
    logic        cmpt_cidx_upd;
    logic [10:0] cmpt_cidx_qid;
    logic [15:0] cmpt_armed;
    logic        dsc_sts_valid;
    logic [10:0] dsc_sts_qid;
    logic        dsc_sts_qinv;
    logic [15:0] dsc_sts_credits;
    int          err_total = 0;
    int          checks = 0;
    int          cycles = 0;

    qca_function_map_select_regs i_dut (
        .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_from_pf(reg_from_pf), .reg_rdata(reg_rdata),
        .qwin_valid(qwin_valid), .qwin_func(qwin_func), .qwin_lqid(qwin_lqid),
        .qwin_phys_valid(qwin_phys_valid), .qwin_phys_qid(qwin_phys_qid),
        .qwin_error(qwin_error), .cmpt_cidx_upd(cmpt_cidx_upd),
        .cmpt_cidx_qid(cmpt_cidx_qid), .cmpt_armed(cmpt_armed),
        .dsc_sts_valid(dsc_sts_valid), .dsc_sts_qid(dsc_sts_qid),
        .dsc_sts_qinv(dsc_sts_qinv), .dsc_sts_credits(dsc_sts_credits)
    );

    // 40 MHz clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // a hang is cut short well past the few hundred cycles the run needs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (err_total == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    function automatic logic [31:0] cw(input logic [12:0] idx, input logic [1:0] op,
                                       input logic [3:0] sel);
        return {12'h000, idx, op, sel, 1'b0};
    endfunction

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_we    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_we <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so look at its middle
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clock);
        reg_re   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_re <= 1'b0;
        @(negedge clock);
        `CHK(reg_rdata, e, "register read")
    endtask

    // masks all ones, context value in words 0 and 1, the rest zero
    task automatic load(input logic [31:0] w0, input logic [31:0] w1);
        for (int i = 0; i < 8; i++) begin
            wr(qca_pkg::OFS_MASK0 + 12'(4 * i), 32'hffff_ffff);
            wr(qca_pkg::OFS_DATA0 + 12'(4 * i), i == 0 ? w0 : (i == 1 ? w1 : 32'h0));
        end
    endtask

    // launch a command, then judge the status pulse two cycles later
    task automatic cmd_go(input logic [31:0] w, input logic s, input logic [10:0] q,
                          input logic [15:0] c);
        wr(qca_pkg::OFS_CMD, w);
        @(negedge clock);
        @(negedge clock);
        `CHK(dsc_sts_valid, s, "status pulse")
        `CHK(dsc_sts_qinv, s, "invalidated flag")
        if (s) begin
            `CHK(dsc_sts_qid, q, "status queue")
            `CHK(dsc_sts_credits, c, "returned credits")
        end
    endtask

    task automatic qw(input logic [12:0] f, input logic [10:0] l, input logic ok,
                      input logic [10:0] p);
        @(posedge clock);
        qwin_valid <= 1'b1;
        qwin_func  <= f;
        qwin_lqid  <= l;
        @(posedge clock);
        qwin_valid <= 1'b0;
        @(negedge clock);
        `CHK(qwin_phys_valid, ok, "window in range")
        `CHK(qwin_error, !ok, "window cancelled")
        if (ok)
            `CHK(qwin_phys_qid, p, "physical queue")
    endtask

    task automatic t_reset();
        rd(qca_pkg::OFS_DATA0, 32'h0);
        rd(qca_pkg::OFS_MASK7, 32'h0);
        rd(qca_pkg::OFS_CMD, 32'h0);
        rd(12'h900, 32'h0);
        `CHK(cmpt_armed, 16'h0, "unarmed after reset")
        load(32'h0, 32'h0);
        cmd_go(cw(13'h0, qca_pkg::OP_WRITE, qca_pkg::SEL_HOST_PROFILE), 1'b0, 11'h0, 16'h0);
    endtask

    // function 3 gets four queues from base 5; reserved ones must not stick
    task automatic t_function_map_select();
        load(32'hffff_f805, 32'hffff_f004);
        cmd_go(cw(13'h3, qca_pkg::OP_WRITE, qca_pkg::SEL_FUNCTION_MAP_SELECT), 1'b0, 11'h0, 16'h0);
        load(32'h0, 32'h0);
        cmd_go(cw(13'h3, qca_pkg::OP_READ, qca_pkg::SEL_FUNCTION_MAP_SELECT), 1'b0, 11'h0, 16'h0);
        rd(qca_pkg::OFS_DATA0, 32'h0000_0005);
        rd(qca_pkg::OFS_DATA0 + 12'h004, 32'h0000_0004);
    endtask

    task automatic t_window();
        qw(13'h3, 11'h3, 1'b1, 11'h008);
        qw(13'h3, 11'h4, 1'b0, 11'h0);
        rd(qca_pkg::OFS_ERR, 32'h1);
        wr(qca_pkg::OFS_ERR, 32'h1);
        rd(qca_pkg::OFS_ERR, 32'h0);
        qw(13'h14, 11'h0, 1'b0, 11'h0);
        reg_from_pf <= 1'b0;
        wr(qca_pkg::OFS_DATA0, 32'h1234_5678);
        reg_from_pf <= 1'b1;
        rd(qca_pkg::OFS_DATA0, 32'h0000_0005);
    endtask

    // software context of queue 2: enable bit set, credits 0x1234
    task automatic t_queue_ops();
        load(32'ha5a5_a5a5, 32'h1234_0001);
        wr(qca_pkg::OFS_CMD, cw(13'h2, qca_pkg::OP_WRITE, qca_pkg::SEL_SW_DESC));
        reg_re   <= 1'b1;
        reg_addr <= qca_pkg::OFS_CMD;
        @(posedge clock);
        reg_re <= 1'b0;
        @(negedge clock);
        `CHK(reg_rdata, cw(13'h2, qca_pkg::OP_WRITE, qca_pkg::SEL_SW_DESC) | 32'h1, "busy")
        rd(qca_pkg::OFS_CMD, cw(13'h2, qca_pkg::OP_WRITE, qca_pkg::SEL_SW_DESC));
        cmd_go(cw(13'h2, qca_pkg::OP_INV, qca_pkg::SEL_SW_DESC) | 32'h1, 1'b0, 11'h0, 16'h0);
        cmd_go(cw(13'h2, qca_pkg::OP_INV, qca_pkg::SEL_SW_DESC), 1'b1, 11'h2, 16'h1234);
        cmd_go(cw(13'h2, qca_pkg::OP_READ, qca_pkg::SEL_SW_DESC), 1'b0, 11'h0, 16'h0);
        rd(qca_pkg::OFS_DATA0, 32'ha5a5_a5a5);
        rd(qca_pkg::OFS_DATA0 + 12'h004, 32'h1234_0000);
        cmd_go(cw(13'h2, qca_pkg::OP_CLEAR, qca_pkg::SEL_SW_DESC), 1'b1, 11'h2, 16'h0);
        cmd_go(cw(13'h2, qca_pkg::OP_READ, qca_pkg::SEL_SW_DESC), 1'b0, 11'h0, 16'h0);
        rd(qca_pkg::OFS_DATA0, 32'h0);
        rd(qca_pkg::OFS_DATA0 + 12'h004, 32'h0);
    endtask

    // timer context ignores clear but honours invalidate
    task automatic t_timer();
        load(32'h1111_1111, 32'h0000_0001);
        cmd_go(cw(13'h1, qca_pkg::OP_WRITE, qca_pkg::SEL_TIMER), 1'b0, 11'h0, 16'h0);
        cmd_go(cw(13'h1, qca_pkg::OP_CLEAR, qca_pkg::SEL_TIMER), 1'b0, 11'h0, 16'h0);
        cmd_go(cw(13'h1, qca_pkg::OP_READ, qca_pkg::SEL_TIMER), 1'b0, 11'h0, 16'h0);
        rd(qca_pkg::OFS_DATA0, 32'h1111_1111);
        cmd_go(cw(13'h1, qca_pkg::OP_INV, qca_pkg::SEL_TIMER), 1'b1, 11'h1, 16'h0);
    endtask

    task automatic t_arm();
        @(posedge clock);
        cmpt_cidx_upd <= 1'b1;
        cmpt_cidx_qid <= 11'h5;
        @(posedge clock);
        cmpt_cidx_upd <= 1'b0;
        @(negedge clock);
        `CHK(cmpt_armed, 16'h0020, "armed by update")
        cmd_go(cw(13'h5, qca_pkg::OP_CLEAR, qca_pkg::SEL_CMPT), 1'b1, 11'h5, 16'h0);
        `CHK(cmpt_armed, 16'h0, "disarmed by clear")
    endtask

    // reset held for ten cycles, then the scenarios in turn
    initial begin
        sys_rst       = 1'b1;
        reg_addr      = 12'h0;
        reg_wdata     = 32'h0;
        reg_we        = 1'b0;
        reg_re        = 1'b0;
        reg_from_pf   = 1'b1;
        qwin_valid    = 1'b0;
        qwin_func     = 13'h0;
        qwin_lqid     = 11'h0;
        cmpt_cidx_upd = 1'b0;
        cmpt_cidx_qid = 11'h0;
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        t_reset();
        t_function_map_select();
        t_window();
        t_queue_ops();
        t_timer();
        t_arm();
        end_of_test();
    end
endmodule
